// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import usart_pkg::*;
    logic clock;
    logic arst_n;
    bus_req_t bus;
    logic [7:0] rdata;
    logic sleep_mode;
    pin_in_t pin_i;
    pin_out_t pin_o;
    logic rx_irq_req;
    logic tx_irq_req;
    logic wake_req;
    logic isr_req;
    logic peer_ck;
    logic peer_dt;
    logic [8:0] got;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    assign pin_i = {pin_o.ck_oe ? pin_o.ck : peer_ck, pin_o.dt_oe ? pin_o.dt : peer_dt};

    usart_sync #(.DIV_W(16)) i_usart_sync (
        .clock(clock),
        .arst_n(arst_n),
        .bus(bus),
        .rdata(rdata),
        .sleep_mode(sleep_mode),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .rx_irq_req(rx_irq_req),
        .tx_irq_req(tx_irq_req),
        .wake_req(wake_req),
        .isr_req(isr_req)
    );

    usart_peer i_usart_peer (
        .ck_wire(pin_i.ck),
        .dt_wire(pin_i.dt),
        .ck_drv(peer_ck),
        .dt_drv(peer_dt)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // --------
    // helpers
    // --------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares = miscompares + 1;
            $display("BAD timeout expected finish seen hang");
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        @(posedge clock);
    endtask

    task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        @(negedge clock);
        chk(what, {1'b0, exp}, {1'b0, rdata});
        @(posedge clock);
    endtask

    task automatic wait_flag(input logic tx);
        int k;
        k = 0;
        while ((tx ? tx_irq_req : rx_irq_req) !== 1'b1 && k < 2000) begin
            @(negedge clock);
            k++;
        end
        chk("flag wait", 9'h1, (k < 2000) ? 9'h1 : 9'h0);
        // realign so the next bus call starts right after a rising edge
        @(posedge clock);
    endtask

    // --------
    // tests
    // --------
    initial begin
        arst_n = 1'b0;
        bus = '0;
        sleep_mode = 1'b0;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd("rsc reset", ADDR_RSC, CTRL_RST);
        wr(ADDR_RSC, 8'h03);
        rd("rsc ro bits", ADDR_RSC, 8'h00);
        rd("txd wo", ADDR_TXD, 8'h00);
        $display("test registers done");

        wr(ADDR_DIVL, 8'h01);
        wr(ADDR_DIVH, 8'h05);
        rd("divisor high", ADDR_DIVH, 8'h05);
        wr(ADDR_TSC, 8'h90);
        wr(ADDR_RSC, 8'h80);
        wr(ADDR_IRQ, 8'h60);
        chk("clock drive", 9'h1, {8'h0, pin_o.ck_oe});
        i_usart_peer.mrx_load(9'h0a5);
        wr(ADDR_RSC, 8'ha0);
        n = 0;
        while (pin_o.ck !== 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (pin_o.ck === 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
        // high byte ignored without wide select: 16 * (1 + 1)
        chk("half period", 9'd32, n[8:0]);
        wait_flag(1'b0);
        chk("wake", 9'h1, {8'h0, wake_req});
        chk("service", 9'h0, {8'h0, isr_req});
        i_usart_peer.release_dt();
        rd("single clears", ADDR_RSC, 8'h80);
        rd("rx byte", ADDR_RXD, 8'ha5);
        chk("rx drained", 9'h0, {8'h0, rx_irq_req});
        $display("test master_rx8 done");

        i_usart_peer.mrx_load(9'h15a);
        wr(ADDR_RSC, 8'hc0);
        wr(ADDR_RSC, 8'he0);
        wait_flag(1'b0);
        i_usart_peer.release_dt();
        rd("ninth bit", ADDR_RSC, 8'hc1);
        rd("rx9 byte", ADDR_RXD, 8'h5a);
        wr(ADDR_BAUD, 8'h10);
        chk("idle polarity", 9'h1, {8'h0, pin_o.ck});
        wr(ADDR_BAUD, 8'h00);
        $display("test master_rx9 done");

        wr(ADDR_RSC, 8'h00);
        wr(ADDR_TSC, 8'h10);
        wr(ADDR_RSC, 8'h90);
        sleep_mode <= 1'b1;
        chk("slave clock", 9'h0, {8'h0, pin_o.ck_oe});
        chk("slave rx dir", 9'h0, {8'h0, pin_o.dt_oe});
        i_usart_peer.send(9'h011, 8);
        wait_flag(1'b0);
        chk("sleep wake", 9'h1, {8'h0, wake_req});
        i_usart_peer.send(9'h022, 8);
        i_usart_peer.send(9'h033, 8);
        repeat (8) @(posedge clock);
        rd("overrun", ADDR_RSC, 8'h92);
        rd("fifo head", ADDR_RXD, 8'h11);
        rd("fifo next", ADDR_RXD, 8'h22);
        i_usart_peer.send(9'h044, 8);
        repeat (8) @(posedge clock);
        chk("held off", 9'h0, {8'h0, rx_irq_req});
        wr(ADDR_RSC, 8'h80);
        rd("overrun clear", ADDR_RSC, 8'h80);
        sleep_mode <= 1'b0;
        $display("test slave_rx done");

        wr(ADDR_TSC, 8'h30);
        wr(ADDR_IRQ, 8'hd0);
        wr(ADDR_TXD, 8'h3c);
        wr(ADDR_TXD, 8'hc3);
        sleep_mode <= 1'b1;
        chk("tx drive", 9'h1, {8'h0, pin_o.dt_oe});
        chk("second waits", 9'h0, {8'h0, tx_irq_req});
        i_usart_peer.recv(8, got);
        chk("first word", 9'h03c, got);
        wait_flag(1'b1);
        chk("tx wake", 9'h1, {8'h0, wake_req});
        chk("tx service", 9'h1, {8'h0, isr_req});
        i_usart_peer.recv(8, got);
        chk("second word", 9'h0c3, got);
        $display("test slave_tx done");
        print_verdict();
    end
endmodule

// ==== usart_peer.sv ====
`timescale 1ns/1ps
module usart_peer (
    input wire logic ck_wire,
    input wire logic dt_wire,
    output logic ck_drv,
    output logic dt_drv
);
    localparam int HALF_NS = 32;
    logic mrx_on;
    logic [8:0] mrx_word;
    int mrx_idx;

    initial begin
        ck_drv = 1'b0;
        dt_drv = 1'b0;
        mrx_on = 1'b0;
        mrx_word = 9'h000;
        mrx_idx = 0;
    end

    // --------
    // port clocks us: next bit on each leading edge
    // --------
    always @(posedge ck_wire) begin
        if (mrx_on) begin
            dt_drv = mrx_word[mrx_idx];
            mrx_idx = mrx_idx + 1;
        end
    end

    task automatic mrx_load(input logic [8:0] w);
        mrx_word = w;
        mrx_idx = 0;
        mrx_on = 1'b1;
    endtask

    // released line shows the inverse, so a stale bit cannot pass
    task automatic release_dt();
        mrx_on = 1'b0;
        dt_drv = ~dt_drv;
    endtask

    // --------
    // we clock the port; clock stands still between frames
    // --------
    task automatic send(input logic [8:0] w, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            ck_drv = 1'b1;
            dt_drv = w[i];
            #(HALF_NS);
            ck_drv = 1'b0;
            #(HALF_NS);
        end
        dt_drv = ~dt_drv;
    endtask

    task automatic recv(input int nbits, output logic [8:0] w);
        w = 9'h000;
        for (int i = 0; i < nbits; i++) begin
            ck_drv = 1'b1;
            #(HALF_NS);
            ck_drv = 1'b0;
            w[i] = dt_wire;
            #(HALF_NS);
        end
    endtask
endmodule

// ==== usart_pkg.sv ====
package usart_pkg;

    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [2:0] ADDR_TSC = 3'h0;
    localparam logic [2:0] ADDR_RSC = 3'h1;
    localparam logic [2:0] ADDR_BAUD = 3'h2;
    localparam logic [2:0] ADDR_DIVL = 3'h3;
    localparam logic [2:0] ADDR_DIVH = 3'h4;
    localparam logic [2:0] ADDR_TXD = 3'h5;
    localparam logic [2:0] ADDR_RXD = 3'h6;
    localparam logic [2:0] ADDR_IRQ = 3'h7;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int TS_CLK_MASTER = 7;
    localparam int TS_NINE = 6;
    localparam int TS_TRANSMIT_ENABLE = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_HIGH_SPEED = 2;
    localparam int TS_SHIFT_IDLE = 1;
    localparam int TS_NINTH = 0;
    localparam int RS_PORT_EN = 7;
    localparam int RS_NINE = 6;
    localparam int RS_SINGLE = 5;
    localparam int RS_CONT = 4;
    localparam int RS_OVERRUN = 1;
    localparam int RS_NINTH = 0;
    localparam int BC_RX_IDLE = 6;
    localparam int BC_POLARITY = 4;
    localparam int BC_WIDE = 3;
    localparam int IR_GLOBAL = 7;
    localparam int IR_PERIPH = 6;
    localparam int IR_RX_EN = 5;
    localparam int IR_TX_EN = 4;
    localparam int IR_RX_FLAG = 1;
    localparam int IR_TX_FLAG = 0;

    // ----------------------------------------
    // writable bits and reset values
    // ----------------------------------------
    localparam logic [7:0] TSC_WMASK = 8'hf5;
    localparam logic [7:0] RSC_WMASK = 8'hf0;
    localparam logic [7:0] BAUD_WMASK = 8'h18;
    localparam logic [7:0] IRQ_WMASK = 8'hf0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ----------------------------------------
    // baud prescale per mode, minus one
    // ----------------------------------------
    localparam logic [4:0] PRE_LOW = 5'h0f;
    localparam logic [4:0] PRE_WIDE = 5'h03;
    localparam logic [4:0] PRE_HIGH = 5'h00;
    localparam int FIFO_DEPTH = 2;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic ck;
        logic dt;
    } pin_in_t;

    typedef struct packed {
        logic ck;
        logic ck_oe;
        logic dt;
        logic dt_oe;
    } pin_out_t;

    function automatic logic [3:0] char_last(input logic nine);
        return nine ? 4'h8 : 4'h7;
    endfunction

endpackage

// ==== usart_sync.sv ====
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - master only with sync, enable, clock-master set
// - master rate from split 16-bit divisor
// - nine-bit receive takes nine bits
// - receive flag on full character, gated request
// - status shows ninth bit and overrun
// - data read returns oldest character low byte
// - overrun cleared by continuous-off or port-off
// - slave when sync, enable set, master clear
// - slave transmits only with both enables clear
// - first word moves straight into shifter
// - second word waits, empty flag on move
// - transmit-empty wakes, global enable calls service
// - data write starts slave transmission
// - slave receives on continuous enable only
// - slave receives while asleep and wakes
// - ninth received bit in status register
// - sample on trailing edge into two-entry fifo
// - single receive clocks one character, self-clears
// - data changes on leading edge, one bit/cycle
// - third character sets overrun, fifo kept
module usart_sync #(
    parameter int DIV_W = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire usart_pkg::bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic sleep_mode,
    input wire usart_pkg::pin_in_t pin_i,
    output usart_pkg::pin_out_t pin_o,
    output logic rx_irq_req,
    output logic tx_irq_req,
    output logic wake_req,
    output logic isr_req
);
    import usart_pkg::*;

    if (DIV_W < 8 || DIV_W > 16) begin : g_chk
        $error("divisor width must be 8 to 16");
    end

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_q_r;
    logic rst_n;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_q_r <= 2'b00;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'b1};
        end
    end
    assign rst_n = rst_q_r[1];

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [7:0] tsc_r, rsc_r, baud_r, divl_r, divh_r, irq_r;
    logic wr_tsc, wr_rsc, wr_txd, rd_rxd;
    logic sync_m, port_enable, clock_master_select, continuous_receive_enable, single_receive_enable, rx9, tx9, transmit_enable;
    logic clock_polarity_select, wide, high_speed_baud_select;
    logic port_on, master, slave, rx_mode, rx_en, tx_on;

    assign wr_tsc = bus.wr && bus.addr == ADDR_TSC;
    assign wr_rsc = bus.wr && bus.addr == ADDR_RSC;
    assign wr_txd = bus.wr && bus.addr == ADDR_TXD;
    assign rd_rxd = bus.rd && bus.addr == ADDR_RXD;

    assign sync_m = tsc_r[TS_SYNC];
    assign clock_master_select = tsc_r[TS_CLK_MASTER];
    assign tx9 = tsc_r[TS_NINE];
    assign transmit_enable = tsc_r[TS_TRANSMIT_ENABLE];
    assign high_speed_baud_select = tsc_r[TS_HIGH_SPEED];
    assign port_enable = rsc_r[RS_PORT_EN];
    assign rx9 = rsc_r[RS_NINE];
    assign single_receive_enable = rsc_r[RS_SINGLE];
    assign continuous_receive_enable = rsc_r[RS_CONT];
    assign clock_polarity_select = baud_r[BC_POLARITY];
    assign wide = baud_r[BC_WIDE];

    assign port_on = port_enable && sync_m;
    assign master = port_on && clock_master_select;
    assign slave = port_on && !clock_master_select;
    assign rx_mode = continuous_receive_enable || single_receive_enable;
    // single receive means nothing without our own clock
    assign rx_en = master ? rx_mode : continuous_receive_enable;
    assign tx_on = port_on && !rx_mode && transmit_enable;

    logic rx_done;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tsc_r <= CTRL_RST;
            rsc_r <= CTRL_RST;
            baud_r <= CTRL_RST;
            divl_r <= CTRL_RST;
            divh_r <= CTRL_RST;
            irq_r <= CTRL_RST;
        end else begin
            // a software write in the same cycle overrides
            if (master && rx_done && single_receive_enable) begin
                rsc_r[RS_SINGLE] <= 1'b0;
            end
            if (wr_tsc) begin
                tsc_r <= bus.wdata & TSC_WMASK;
            end
            if (wr_rsc) begin
                rsc_r <= bus.wdata & RSC_WMASK;
            end
            if (bus.wr && bus.addr == ADDR_BAUD) begin
                baud_r <= bus.wdata & BAUD_WMASK;
            end
            if (bus.wr && bus.addr == ADDR_DIVL) begin
                divl_r <= bus.wdata;
            end
            if (bus.wr && bus.addr == ADDR_DIVH) begin
                divh_r <= bus.wdata;
            end
            if (bus.wr && bus.addr == ADDR_IRQ) begin
                irq_r <= bus.wdata & IRQ_WMASK;
            end
        end
    end

    // ----------------------------------------
    // pin synchronisers and slave edges
    // ----------------------------------------
    logic [1:0] ck_q_r, dt_q_r;
    logic act_d_r, s_act, s_lead, s_trail;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ck_q_r <= 2'b00;
            dt_q_r <= 2'b00;
            act_d_r <= 1'b0;
        end else begin
            ck_q_r <= {ck_q_r[0], pin_i.ck};
            dt_q_r <= {dt_q_r[0], pin_i.dt};
            act_d_r <= s_act;
        end
    end

    assign s_act = ck_q_r[1] ^ clock_polarity_select;
    assign s_lead = slave && s_act && !act_d_r;
    assign s_trail = slave && !s_act && act_d_r;

    // ----------------------------------------
    // master clock generator
    // ----------------------------------------
    logic [4:0] pre_r, pre_max;
    logic [DIV_W-1:0] div_cnt_r, divisor;
    logic phase_r, run, tick, lead, trail;
    logic tx_busy_r, overrun_error_flag_r;

    assign divisor = wide ? DIV_W'({divh_r, divl_r}) : DIV_W'(divl_r);
    assign pre_max = high_speed_baud_select ? PRE_HIGH : (wide ? PRE_WIDE : PRE_LOW);
    // stopping run drops the clock at once, mid character too
    assign run = master && !sleep_mode
        && ((rx_mode && !overrun_error_flag_r) || tx_busy_r);
    assign tick = run && pre_r == pre_max && div_cnt_r == divisor;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pre_r <= '0;
            div_cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (!run) begin
            pre_r <= '0;
            div_cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (pre_r == pre_max) begin
            pre_r <= '0;
            if (div_cnt_r == divisor) begin
                div_cnt_r <= '0;
                phase_r <= !phase_r;
            end else begin
                div_cnt_r <= div_cnt_r + 1'b1;
            end
        end else begin
            pre_r <= pre_r + 5'h01;
        end
    end

    assign lead = master ? (tick && !phase_r) : s_lead;
    assign trail = master ? (tick && phase_r) : s_trail;

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    logic [8:0] hold_r, tsr_r;
    logic hold_full_r, tx_load, tx_last;
    logic [3:0] tx_cnt_r;

    assign tx_load = tx_on && hold_full_r && !tx_busy_r;
    assign tx_last = tx_busy_r && trail && tx_cnt_r == char_last(tx9);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hold_r <= '0;
            hold_full_r <= 1'b0;
        end else if (!port_enable) begin
            hold_full_r <= 1'b0;
        end else begin
            if (wr_txd) begin
                hold_r <= {tsc_r[TS_NINTH], bus.wdata};
            end
            // a new word wins over the move to the shifter
            hold_full_r <= wr_txd || (hold_full_r && !tx_load);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tsr_r <= '0;
            tx_busy_r <= 1'b0;
            tx_cnt_r <= '0;
        end else if (!tx_on) begin
            tx_busy_r <= 1'b0;
            tx_cnt_r <= '0;
        end else if (tx_load) begin
            tsr_r <= hold_r;
            tx_busy_r <= 1'b1;
            tx_cnt_r <= '0;
        end else if (tx_busy_r && trail) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            if (tx_last) begin
                tx_busy_r <= 1'b0;
            end
        end else if (tx_busy_r && lead && tx_cnt_r != 4'h0) begin
            tsr_r <= {1'b0, tsr_r[8:1]};
        end
    end

    assign pin_o.dt = tsr_r[0];
    assign pin_o.dt_oe = tx_on;
    assign pin_o.ck = phase_r ^ clock_polarity_select;
    assign pin_o.ck_oe = master;

    // ----------------------------------------
    // receiver and two-entry fifo
    // ----------------------------------------
    logic [8:0] rsr_r, rx_word;
    logic [3:0] rx_cnt_r;
    logic rx_go, push, pop, ovr;
    logic [8:0] fifo_r [FIFO_DEPTH];
    logic [1:0] cnt_r, wr_pos;

    assign rx_go = port_on && rx_en && !overrun_error_flag_r;
    assign rx_done = rx_go && trail
        && rx_cnt_r == char_last(rx9);

    always_comb begin
        rx_word = rsr_r;
        rx_word[rx_cnt_r] = dt_q_r[1];
        if (!rx9) begin
            rx_word[8] = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rsr_r <= '0;
            rx_cnt_r <= '0;
        end else if (!rx_go) begin
            rx_cnt_r <= '0;
        end else if (trail) begin
            rsr_r[rx_cnt_r] <= dt_q_r[1];
            rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
        end
    end

    assign pop = rd_rxd && cnt_r != 2'd0;
    assign push = rx_done && (cnt_r != 2'd2 || pop);
    assign ovr = rx_done && cnt_r == 2'd2 && !pop;
    assign wr_pos = cnt_r - {1'b0, pop};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fifo_r[0] <= '0;
            fifo_r[1] <= '0;
            cnt_r <= '0;
        end else if (!port_enable) begin
            cnt_r <= '0;
        end else begin
            if (pop) begin
                fifo_r[0] <= fifo_r[1];
            end
            if (push) begin
                fifo_r[wr_pos[0]] <= rx_word;
            end
            cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            overrun_error_flag_r <= 1'b0;
        end else if (ovr) begin
            overrun_error_flag_r <= 1'b1;
        end else if (!port_enable || (wr_rsc && !bus.wdata[RS_CONT])
                || (rd_rxd && !continuous_receive_enable)) begin
            overrun_error_flag_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // flags, requests, read port
    // ----------------------------------------
    logic rx_flag, tx_flag;
    logic [7:0] rd_mux, rdata_r;

    assign rx_flag = cnt_r != 2'd0;
    assign tx_flag = !hold_full_r;
    assign rx_irq_req = rx_flag && irq_r[IR_RX_EN];
    assign tx_irq_req = tx_flag && irq_r[IR_TX_EN];
    // wake in slave mode still depends on the system clock: synchronised pin edges and a registered fifo count
    assign wake_req = irq_r[IR_PERIPH]
        && (rx_irq_req || tx_irq_req);
    assign isr_req = wake_req && irq_r[IR_GLOBAL];

    always_comb begin
        rd_mux = 8'h00;
        case (bus.addr)
            ADDR_TSC: begin
                rd_mux = tsc_r;
                rd_mux[TS_SHIFT_IDLE] = !tx_busy_r;
            end
            ADDR_RSC: begin
                rd_mux = rsc_r;
                rd_mux[RS_OVERRUN] = overrun_error_flag_r;
                rd_mux[RS_NINTH] = rx9 && fifo_r[0][8];
            end
            ADDR_BAUD: begin
                rd_mux = baud_r;
                rd_mux[BC_RX_IDLE] = rx_cnt_r == 4'h0;
            end
            ADDR_DIVL: rd_mux = divl_r;
            ADDR_DIVH: rd_mux = divh_r;
            ADDR_TXD: rd_mux = 8'h00;
            ADDR_RXD: rd_mux = rx_flag ? fifo_r[0][7:0] : 8'h00;
            ADDR_IRQ: begin
                rd_mux = irq_r;
                rd_mux[IR_RX_FLAG] = rx_flag;
                rd_mux[IR_TX_FLAG] = tx_flag;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= bus.rd ? rd_mux : 8'h00;
        end
    end
    assign rdata = rdata_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_ck_idle_level: assert property (master && !run |=> pin_o.ck == clock_polarity_select)
        else $error("master clock not idle at polarity");
    a_slave_ck_input: assert property (slave |-> !pin_o.ck_oe)
        else $error("slave drives clock line");
    a_tx_direction: assert property (pin_o.dt_oe |-> !continuous_receive_enable && !single_receive_enable && transmit_enable)
        else $error("data driven while receiving");
    a_rx_flag_set: assert property (push |=> rx_flag && cnt_r != 2'd0)
        else $error("receive flag missing after character");
    a_overrun_keep: assert property (ovr |=> overrun_error_flag_r && cnt_r == 2'd2
        && fifo_r[0] == $past(fifo_r[0]))
        else $error("overrun lost or fifo disturbed");
    a_overrun_clear: assert property (!port_enable |=> !overrun_error_flag_r)
        else $error("overrun survives port disable");
    a_single_stop: assert property (master && rx_done && !continuous_receive_enable && !wr_rsc
        |=> !single_receive_enable ##1 !rx_done [*2])
        else $error("single receive not self-cleared");
    a_tx_second: assert property (tx_load && !wr_txd
        |=> !hold_full_r && tx_busy_r && tx_flag)
        else $error("holding word not moved");
    a_tx_shift: assert property (tx_on && tx_busy_r && lead && tx_cnt_r != 4'h0
        |=> tsr_r == ($past(tsr_r) >> 1))
        else $error("shift not on leading edge");

    c_nine_bit_rx: cover property (rx_done && rx9);
    c_overrun: cover property (ovr);
    c_slave_tx: cover property (slave && tx_load);
    c_single_done: cover property (master && rx_done && single_receive_enable && !continuous_receive_enable);

endmodule
